// File: design/airs_pkg.sv
package airs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] FIRST_PIN_ROUTE_CTRL_OFS = 8'h23;
  localparam logic [7:0] SECOND_PIN_ROUTE_CTRL_OFS = 8'h24;
  localparam logic [7:0] FILTER_SCALE_CONFIG_OFS = 8'h25;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h27;
  localparam logic [7:0] X_ACCEL_LOW_BYTE_OFS = 8'h28;
  localparam logic [7:0] X_ACCEL_HIGH_BYTE_OFS = 8'h29;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [1:0] CUTOFF_RESET = 2'h0;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic FILTER_PATH_RESET = 1'b0;
  localparam logic LOW_NOISE_RESET = 1'b0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ---------------------------------------------------------------
  // first pin routing bits, also the event vector order
  // ---------------------------------------------------------------
  localparam int PIN_A_ORIENT_BIT = 7;
  localparam int PIN_A_ONE_KNOCK_BIT = 6;
  localparam int PIN_A_WAKEUP_BIT = 5;
  localparam int PIN_A_FREEFALL_BIT = 4;
  localparam int PIN_A_TWO_KNOCK_BIT = 3;
  localparam int PIN_A_BUF_FULL_BIT = 2;
  localparam int PIN_A_BUF_LEVEL_BIT = 1;
  localparam int PIN_A_NEW_SAMPLE_BIT = 0;

  // ---------------------------------------------------------------
  // second pin routing bits
  // ---------------------------------------------------------------
  localparam int PIN_B_SLEEPING_BIT = 7;
  localparam int PIN_B_SLEEP_TOGGLE_BIT = 6;
  localparam int PIN_B_TRIM_RELOAD_BIT = 5;
  localparam int PIN_B_TEMP_SAMPLE_BIT = 4;
  localparam int PIN_B_OVERRUN_BIT = 3;
  localparam int PIN_B_BUF_FULL_BIT = 2;
  localparam int PIN_B_BUF_LEVEL_BIT = 1;
  localparam int PIN_B_NEW_SAMPLE_BIT = 0;

  // ---------------------------------------------------------------
  // filter and scale fields, status bits
  // ---------------------------------------------------------------
  localparam int CUTOFF_LSB = 6;
  localparam int RANGE_LSB = 4;
  localparam int FILTER_PATH_BIT = 3;
  localparam int LOW_NOISE_BIT = 2;
  localparam int STAT_BUF_LEVEL_BIT = 7;
  localparam int STAT_WAKEUP_BIT = 6;
  localparam int STAT_SLEEP_BIT = 5;
  localparam int STAT_TWO_KNOCK_BIT = 4;
  localparam int STAT_ONE_KNOCK_BIT = 3;
  localparam int STAT_ORIENT_BIT = 2;
  localparam int STAT_FREEFALL_BIT = 1;
  localparam int STAT_NEW_SAMPLE_BIT = 0;

  // low power encoding with 12-bit output
  localparam logic [1:0] LOW_POWER_12BIT = 2'h0;

endpackage

// File: design/airs_pin_route.sv
`timescale 1ns/1ps
`default_nettype none

module airs_pin_route #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] enable,
  input wire logic [WIDTH-1:0] events,
  output logic pin
);

  typedef struct packed {
    logic pin;
  } airs_route_state_type;

  airs_route_state_type state_q;
  airs_route_state_type state_d;
  logic [WIDTH-1:0] gated;

  // ---------------------------------------------------------------
  // per event gating
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_gate
      assign gated[i] = enable[i] & events[i];
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    state_d.pin = |gated;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pin = state_q.pin;

  a_pin_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (enable == '0) |=> !pin) else $error("pin raised with all enables off");

endmodule

`default_nettype wire

// File: design/airs_x_capture.sv
`timescale 1ns/1ps
`default_nettype none

module airs_x_capture (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [15:0] sample_x,
  input wire logic sample_valid,
  input wire logic block_update,
  input wire logic [1:0] low_power_select,
  input wire logic read_low,
  input wire logic read_high,
  output logic [7:0] out_low,
  output logic [7:0] out_high
);

  typedef enum logic [1:0] {
    AIRS_CAP_FREE = 2'b01,
    AIRS_CAP_HELD = 2'b10
  } airs_cap_mode_type;

  typedef struct packed {
    airs_cap_mode_type mode;
    logic [15:0] data;
    logic [15:0] pend;
    logic pend_valid;
    logic seen_low;
    logic seen_high;
  } airs_cap_state_type;

  airs_cap_state_type state_q;
  airs_cap_state_type state_d;
  logic [15:0] masked;

  // two lowest bits never carry data; 12-bit mode also drops 3:2
  always_comb begin
    masked = {sample_x[15:2], 2'b00};
    if (low_power_select == airs_pkg::LOW_POWER_12BIT) begin
      masked[3:2] = 2'b00;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q.mode)
      AIRS_CAP_FREE: begin
        if (sample_valid) begin
          state_d.data = masked;
        end
        if (block_update && (read_low ^ read_high)) begin
          state_d.mode = AIRS_CAP_HELD;
          state_d.seen_low = read_low;
          state_d.seen_high = read_high;
          if (sample_valid) begin
            state_d.data = state_q.data;
            state_d.pend = masked;
            state_d.pend_valid = 1'b1;
          end
        end
      end
      AIRS_CAP_HELD: begin
        // newest sample waits so the pair stays coherent
        if (sample_valid) begin
          state_d.pend = masked;
          state_d.pend_valid = 1'b1;
        end
        state_d.seen_low = state_q.seen_low | read_low;
        state_d.seen_high = state_q.seen_high | read_high;
        if ((state_d.seen_low && state_d.seen_high) || !block_update) begin
          state_d.mode = AIRS_CAP_FREE;
          state_d.seen_low = 1'b0;
          state_d.seen_high = 1'b0;
          state_d.pend_valid = 1'b0;
          if (sample_valid) begin
            state_d.data = masked;
          end else if (state_q.pend_valid) begin
            state_d.data = state_q.pend;
          end
        end
      end
      default: begin
        state_d.mode = AIRS_CAP_FREE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{mode: AIRS_CAP_FREE, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign out_low = state_q.data[7:0];
  assign out_high = state_q.data[15:8];

  a_bdu_hold_pair: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q.mode == AIRS_CAP_HELD && block_update && !read_low && !read_high)
    |=> $stable({out_high, out_low})) else $error("output pair changed while held");
  a_lp12_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sample_valid && state_q.mode == AIRS_CAP_FREE && !block_update && low_power_select == 2'h0)
    |=> out_low[3:0] == 4'h0) else $error("12-bit sample kept bits 3:2");
  c_bdu_freeze: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_q.mode == AIRS_CAP_HELD && sample_valid);

endmodule

`default_nettype wire

// File: design/airs_regs.sv
// How it works
// - first routing register: eight enables for pin one
// - pin one bit 3 carries double tap
// - all routing enables reset to zero
// - second routing register: eight enables for pin two
// - temperature sample enable signals on pin two
// - trim reload busy enable shows on pin two
// - overrun enable drives pin two
// - sleep change enable signals each state transition
// - two-bit cutoff field selects filter bandwidth
// - two-bit range field selects full scale
// - filter path bit resets low, picks path
// - status bit 7: buffer at or above threshold
// - status bit 6: wakeup detected
// - status bit 5: sleep event present
// - status bits 4,3: double and single tap
// - status bit 2: orientation change detected
// - status bit 1: free fall detected
// - status bit 0: all axes new sample
// - x low byte, two lowest bits zero
// - 12-bit mode also zeroes low bits 3,2
// - x high byte completes two's complement word
// - block update holds pair until both read
// - latch mode holds events, else pulses
// - low power encoding 00 means 12-bit
`timescale 1ns/1ps
`default_nettype none

module airs_regs (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic block_update,
  input wire logic latch_mode,
  input wire logic [1:0] low_power_select,
  input wire logic orient_event,
  input wire logic one_knock_event,
  input wire logic wakeup_event,
  input wire logic freefall_event,
  input wire logic two_knock_event,
  input wire logic sleeping,
  input wire logic sleep_toggle,
  input wire logic trim_reload_busy,
  input wire logic temp_sample,
  input wire logic buf_overrun,
  input wire logic buf_full,
  input wire logic buf_level_flag,
  input wire logic new_sample,
  input wire logic [15:0] sample_x,
  output logic first_irq_pin,
  output logic second_irq_pin,
  output logic [1:0] cutoff_select,
  output logic [1:0] range_select,
  output logic filter_path_select,
  output logic low_noise_select
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // flags order: orient, one knock, wakeup, freefall, two knock
  typedef struct packed {
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [1:0] cutoff;
    logic [1:0] range;
    logic path;
    logic low_noise;
    logic [4:0] flags;
    logic new_sample_flag;
    logic [7:0] rd_data;
    logic rd_valid;
  } airs_regs_state_type;

  airs_regs_state_type state_q;
  airs_regs_state_type state_d;

  logic [4:0] raw_events;
  logic [7:0] events_a;
  logic [7:0] events_b;
  logic [7:0] status_view;
  logic [7:0] cfg_view;
  logic [7:0] x_low;
  logic [7:0] x_high;
  logic hit_status;
  logic rd_x_low;
  logic rd_x_high;

  assign raw_events = {
    orient_event,
    one_knock_event,
    wakeup_event,
    freefall_event,
    two_knock_event
  };
  assign hit_status = reg_rd_en && (reg_addr == airs_pkg::EVENT_STATUS_OFS);
  assign rd_x_low = reg_rd_en && (reg_addr == airs_pkg::X_ACCEL_LOW_BYTE_OFS);
  assign rd_x_high = reg_rd_en && (reg_addr == airs_pkg::X_ACCEL_HIGH_BYTE_OFS);

  // ---------------------------------------------------------------
  // event vectors feeding the pins
  // ---------------------------------------------------------------
  always_comb begin
    events_a = '0;
    events_a[airs_pkg::PIN_A_ORIENT_BIT] = state_q.flags[4];
    events_a[airs_pkg::PIN_A_ONE_KNOCK_BIT] = state_q.flags[3];
    events_a[airs_pkg::PIN_A_WAKEUP_BIT] = state_q.flags[2];
    events_a[airs_pkg::PIN_A_FREEFALL_BIT] = state_q.flags[1];
    events_a[airs_pkg::PIN_A_TWO_KNOCK_BIT] = state_q.flags[0];
    events_a[airs_pkg::PIN_A_BUF_FULL_BIT] = buf_full;
    events_a[airs_pkg::PIN_A_BUF_LEVEL_BIT] = buf_level_flag;
    events_a[airs_pkg::PIN_A_NEW_SAMPLE_BIT] = state_q.new_sample_flag;
    events_b = '0;
    events_b[airs_pkg::PIN_B_SLEEPING_BIT] = sleeping;
    events_b[airs_pkg::PIN_B_SLEEP_TOGGLE_BIT] = sleep_toggle;
    events_b[airs_pkg::PIN_B_TRIM_RELOAD_BIT] = trim_reload_busy;
    events_b[airs_pkg::PIN_B_TEMP_SAMPLE_BIT] = temp_sample;
    events_b[airs_pkg::PIN_B_OVERRUN_BIT] = buf_overrun;
    events_b[airs_pkg::PIN_B_BUF_FULL_BIT] = buf_full;
    events_b[airs_pkg::PIN_B_BUF_LEVEL_BIT] = buf_level_flag;
    events_b[airs_pkg::PIN_B_NEW_SAMPLE_BIT] = state_q.new_sample_flag;
  end

  // ---------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------
  always_comb begin
    status_view = '0;
    status_view[airs_pkg::STAT_BUF_LEVEL_BIT] = buf_level_flag;
    status_view[airs_pkg::STAT_WAKEUP_BIT] = state_q.flags[2];
    status_view[airs_pkg::STAT_SLEEP_BIT] = sleeping;
    status_view[airs_pkg::STAT_TWO_KNOCK_BIT] = state_q.flags[0];
    status_view[airs_pkg::STAT_ONE_KNOCK_BIT] = state_q.flags[3];
    status_view[airs_pkg::STAT_ORIENT_BIT] = state_q.flags[4];
    status_view[airs_pkg::STAT_FREEFALL_BIT] = state_q.flags[1];
    status_view[airs_pkg::STAT_NEW_SAMPLE_BIT] = state_q.new_sample_flag;
    cfg_view = '0;
    cfg_view[airs_pkg::CUTOFF_LSB +: 2] = state_q.cutoff;
    cfg_view[airs_pkg::RANGE_LSB +: 2] = state_q.range;
    cfg_view[airs_pkg::FILTER_PATH_BIT] = state_q.path;
    cfg_view[airs_pkg::LOW_NOISE_BIT] = state_q.low_noise;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // pulsed mode lets flags track the engine; latched keeps them until status read
    if (latch_mode) begin
      state_d.flags = (state_q.flags & {5{~hit_status}}) | raw_events;
    end else begin
      state_d.flags = raw_events;
    end
    // a new sample arriving with the high byte read still sets the flag
    state_d.new_sample_flag = (state_q.new_sample_flag & ~rd_x_high) | new_sample;
    if (reg_wr_en) begin
      case (reg_addr)
        airs_pkg::FIRST_PIN_ROUTE_CTRL_OFS: begin
          state_d.route_a = reg_wr_data;
        end
        airs_pkg::SECOND_PIN_ROUTE_CTRL_OFS: begin
          state_d.route_b = reg_wr_data;
        end
        airs_pkg::FILTER_SCALE_CONFIG_OFS: begin
          state_d.cutoff = reg_wr_data[airs_pkg::CUTOFF_LSB +: 2];
          state_d.range = reg_wr_data[airs_pkg::RANGE_LSB +: 2];
          state_d.path = reg_wr_data[airs_pkg::FILTER_PATH_BIT];
          state_d.low_noise = reg_wr_data[airs_pkg::LOW_NOISE_BIT];
        end
        default: begin
          // status and x output are read-only; nothing else mapped
          state_d.route_a = state_q.route_a;
        end
      endcase
    end
    state_d.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      case (reg_addr)
        airs_pkg::FIRST_PIN_ROUTE_CTRL_OFS: begin
          state_d.rd_data = state_q.route_a;
        end
        airs_pkg::SECOND_PIN_ROUTE_CTRL_OFS: begin
          state_d.rd_data = state_q.route_b;
        end
        airs_pkg::FILTER_SCALE_CONFIG_OFS: begin
          state_d.rd_data = cfg_view;
        end
        airs_pkg::EVENT_STATUS_OFS: begin
          state_d.rd_data = status_view;
        end
        airs_pkg::X_ACCEL_LOW_BYTE_OFS: begin
          state_d.rd_data = x_low;
        end
        airs_pkg::X_ACCEL_HIGH_BYTE_OFS: begin
          state_d.rd_data = x_high;
        end
        default: begin
          state_d.rd_data = airs_pkg::READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{route_a: airs_pkg::ROUTE_RESET,
                   route_b: airs_pkg::ROUTE_RESET,
                   cutoff: airs_pkg::CUTOFF_RESET,
                   range: airs_pkg::RANGE_RESET,
                   path: airs_pkg::FILTER_PATH_RESET,
                   low_noise: airs_pkg::LOW_NOISE_RESET,
                   flags: 5'h00,
                   new_sample_flag: 1'b0,
                   rd_data: airs_pkg::READ_IDLE,
                   rd_valid: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // pins and sample holding
  // ---------------------------------------------------------------
  airs_pin_route #(.WIDTH(8)) u_pin_a (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(state_q.route_a),
    .events(events_a),
    .pin(first_irq_pin)
  );

  airs_pin_route #(.WIDTH(8)) u_pin_b (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(state_q.route_b),
    .events(events_b),
    .pin(second_irq_pin)
  );

  airs_x_capture u_x_capture (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sample_x(sample_x),
    .sample_valid(new_sample),
    .block_update(block_update),
    .low_power_select(low_power_select),
    .read_low(rd_x_low),
    .read_high(rd_x_high),
    .out_low(x_low),
    .out_high(x_high)
  );

  assign reg_rd_data = state_q.rd_data;
  assign reg_rd_valid = state_q.rd_valid;
  assign cutoff_select = state_q.cutoff;
  assign range_select = state_q.range;
  assign filter_path_select = state_q.path;
  assign low_noise_select = state_q.low_noise;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_pin_a_route: assert property (
    ##1 first_irq_pin == $past(|(state_q.route_a & events_a))) else $error("pin one mismatch");
  a_two_knock_bit3: assert property (
    (state_q.route_a == 8'h08 && state_q.flags[0]) |=> first_irq_pin) else $error("double tap not on pin one");
  a_trim_pin_b: assert property (
    (state_q.route_b == 8'h20) |=> (second_irq_pin == $past(trim_reload_busy))) else $error("trim busy not on pin two");
  a_overrun_pin_b: assert property (
    (state_q.route_b[3] && buf_overrun) |=> second_irq_pin) else $error("overrun not on pin two");
  a_status_level: assert property (
    hit_status |=> reg_rd_valid && reg_rd_data[7] == $past(buf_level_flag)) else $error("status bit 7 wrong");
  a_cfg_write: assert property (
    (reg_wr_en && reg_addr == 8'h25) |=> filter_path_select == $past(reg_wr_data[3]) &&
    range_select == $past(reg_wr_data[5:4])) else $error("config write lost");
  a_cfg_reserved: assert property (
    (reg_rd_en && reg_addr == 8'h25) |=> reg_rd_data[1:0] == 2'b00) else $error("reserved bits set");
  a_x_low_zero: assert property (
    rd_x_low |=> reg_rd_data[1:0] == 2'b00) else $error("x low bits 1:0 not zero");
  a_latch_hold: assert property (
    (latch_mode && state_q.flags[2] && !hit_status) ##1 latch_mode |-> state_q.flags[2])
    else $error("latched wakeup lost");
  a_sample_set_wins: assert property (
    (new_sample && rd_x_high) |=> state_q.new_sample_flag) else $error("new sample lost on read");

  // ---------------------------------------------------------------
  // pin two and register side checks
  // ---------------------------------------------------------------
  // flags lag raw events by one cycle, pins by two for flagged events and one for direct inputs
  a_pin_b_route: assert property (
    ##1 second_irq_pin == $past(|(state_q.route_b & events_b)))
    else $error("pin two mismatch");
  a_temp_pin_b: assert property (
    (state_q.route_b[4] && temp_sample) |=> second_irq_pin)
    else $error("temperature sample not on pin two");
  a_toggle_pin_b: assert property (
    (state_q.route_b[6] && sleep_toggle) |=> second_irq_pin)
    else $error("sleep change not on pin two");
  a_pulse_follow: assert property (
    !latch_mode |=> state_q.flags == $past(raw_events))
    else $error("pulsed flags do not follow events");

  // one port, one write a cycle: stored fields must not move on read-only writes
  a_ro_write_kept: assert property (
    (reg_wr_en && reg_addr inside {8'h27, 8'h28, 8'h29})
    |=> $stable({state_q.route_a, state_q.route_b, cfg_view}))
    else $error("read-only write changed a register");
  a_unmapped_zero: assert property (
    (reg_rd_en && reg_addr == 8'h26) |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_status_sleep: assert property (
    hit_status |=> reg_rd_data[5] == $past(sleeping))
    else $error("status bit 5 wrong");
  a_cutoff_write: assert property (
    (reg_wr_en && reg_addr == 8'h25) |=> cutoff_select == $past(reg_wr_data[7:6]))
    else $error("cutoff write lost");
  a_sample_clear: assert property (
    (rd_x_high && !new_sample) |=> !state_q.new_sample_flag)
    else $error("new sample flag not cleared");
  a_x_high_read: assert property (
    rd_x_high |=> reg_rd_data == $past(x_high))
    else $error("x high byte not presented");

  c_pin_a_fire: cover property (first_irq_pin);
  c_pin_b_fire: cover property (second_irq_pin);
  c_status_clear: cover property (latch_mode && hit_status && state_q.flags != 5'h00);
  c_pulsed_event: cover property (!latch_mode && state_q.flags != 5'h00);

endmodule

`default_nettype wire

// File: sim/airs_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module airs_host (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end

  // idle address and data show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hXX;
  endtask
endmodule

`default_nettype wire

// File: sim/tb_accel_irq_route_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_accel_irq_route_status_regs;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [12:0] ev = 13'h0000;
  logic [15:0] sample_x = 16'h0000;
  logic block_update = 1'b0;
  logic latch_mode = 1'b1;
  logic [1:0] lps = 2'h1;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rdv, v;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, first_irq_pin, second_irq_pin;
  logic filter_path_select, low_noise_select, pin;
  logic [1:0] cutoff_select, range_select;
  logic [31:0] seed = 32'h0E7F;
  logic [31:0] s1, s2;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int idx;
  int st_map [8] = '{0, 9, 12, 11, 8, 7, 10, 1};

  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // event vector: orient, one knock, wakeup, freefall, two knock,
  // sleeping, toggle, trim, temp, overrun, full, level, new sample
  // ----------------------------------------------------------------
  airs_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .block_update(block_update), .latch_mode(latch_mode),
    .low_power_select(lps), .orient_event(ev[12]), .one_knock_event(ev[11]),
    .wakeup_event(ev[10]), .freefall_event(ev[9]), .two_knock_event(ev[8]), .sleeping(ev[7]),
    .sleep_toggle(ev[6]), .trim_reload_busy(ev[5]), .temp_sample(ev[4]), .buf_overrun(ev[3]),
    .buf_full(ev[2]), .buf_level_flag(ev[1]), .new_sample(ev[0]), .sample_x(sample_x),
    .first_irq_pin(first_irq_pin), .second_irq_pin(second_irq_pin),
    .cutoff_select(cutoff_select), .range_select(range_select),
    .filter_path_select(filter_path_select), .low_noise_select(low_noise_select));

  airs_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_ev(input logic [12:0] e);
    @(posedge sys_clk);
    ev <= e;
  endtask

  // one-cycle sample strobe, low power mode set with it
  task automatic load(input logic [15:0] s, input logic [1:0] lp);
    @(posedge sys_clk);
    sample_x <= s;
    lps <= lp;
    ev[0] <= 1'b1;
    @(posedge sys_clk);
    ev[0] <= 1'b0;
    sample_x <= ~s;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] x_low(input logic [15:0] s, input logic [1:0] lp);
    return s[7:0] & ((lp == 2'h0) ? 8'hF0 : 8'hFC);
  endfunction

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    host.rd(8'h23, rdv);
    chk(rdv, 8'h00);
    host.rd(8'h24, rdv);
    chk(rdv, 8'h00);
    host.rd(8'h25, rdv);
    chk({rdv[3], 7'h00}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = {i[1:0], i[1:0], seed[3:0]};
      host.wr(8'h25, v);
      host.rd(8'h25, rdv);
      chk(rdv, v & 8'hFC);
      chk({6'h00, cutoff_select}, {6'h00, v[7:6]});
      chk({6'h00, range_select}, {6'h00, v[5:4]});
      chk({6'h00, filter_path_select, low_noise_select}, {6'h00, v[3:2]});
      host.wr(8'h23, seed[15:8]);
      host.wr(8'h24, seed[23:16]);
      host.rd(8'h23, rdv);
      chk(rdv, seed[15:8]);
      host.rd(8'h24, rdv);
      chk(rdv, seed[23:16]);
    end
    // every other enable set first: a swapped bit shows up as a stray pin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        idx = (p == 0 && i > 2) ? i + 5 : i;
        host.wr(8'(8'h23 + p), ~(8'h01 << i));
        set_ev(13'h0001 << idx);
        tick(4);
        pin = p ? second_irq_pin : first_irq_pin;
        chk({7'h00, pin}, 8'h00);
        host.wr(8'(8'h23 + p), 8'h01 << i);
        tick(3);
        pin = p ? second_irq_pin : first_irq_pin;
        chk({7'h00, pin}, 8'h01);
        set_ev(13'h0000);
        host.wr(8'(8'h23 + p), 8'h00);
        host.rd(8'h27, rdv);
        host.rd(8'h29, rdv);
      end
    end
    for (int k = 0; k < 8; k++) begin
      set_ev(13'h0001 << st_map[k]);
      tick(3);
      host.rd(8'h27, rdv);
      chk(rdv, 8'h01 << k);
      set_ev(13'h0000);
      host.rd(8'h29, rdv);
      host.rd(8'h27, rdv);
      host.rd(8'h27, rdv);
      chk(rdv, 8'h00);
    end
    for (int j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      load(seed[15:0], j[1:0]);
      tick(2);
      host.rd(8'h28, rdv);
      chk(rdv, x_low(seed[15:0], j[1:0]));
      host.rd(8'h29, rdv);
      chk(rdv, seed[15:8]);
    end
    // second sample lands while the pair is held
    s1 = lfsr(seed);
    s2 = lfsr(s1);
    @(posedge sys_clk);
    block_update <= 1'b1;
    load(s1[15:0], 2'h1);
    tick(2);
    host.rd(8'h28, rdv);
    chk(rdv, x_low(s1[15:0], 2'h1));
    load(s2[15:0], 2'h1);
    tick(2);
    host.rd(8'h29, rdv);
    chk(rdv, s1[15:8]);
    host.rd(8'h28, rdv);
    chk(rdv, x_low(s2[15:0], 2'h1));
    for (int a = 8'h26; a < 8'h2A; a++) begin
      host.wr(8'(a), 8'hFF);
    end
    host.rd(8'h29, rdv);
    chk(rdv, s2[15:8]);
    host.rd(8'h28, rdv);
    chk(rdv, x_low(s2[15:0], 2'h1));
    host.rd(8'h27, rdv);
    chk(rdv, 8'h00);
    host.rd(8'h26, rdv);
    chk(rdv, 8'h00);
    // pulsed mode: pin falls with its event, no status read
    host.wr(8'h23, 8'h20);
    set_ev(13'h0400);
    latch_mode <= 1'b0;
    tick(3);
    chk({7'h00, first_irq_pin}, 8'h01);
    set_ev(13'h0000);
    tick(3);
    chk({7'h00, first_irq_pin}, 8'h00);
    // mid-run reset must clear the routing enables again
    host.wr(8'h24, 8'hFF);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    host.rd(8'h24, rdv);
    chk(rdv, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
